/* File: hdl/mpfc_pin_ctrl.sv */
`timescale 1ns/100ps
`include "mpfc_map.svh"
// How it works
// - Interrupt pin senses falling edge only, or falling edge plus low level.
// - Power-on or external reset turns every line of all four ports to input.
// - Each pin has a software pull-up, active only while the pin is input.
// - Converter power-on hands port D pins 0 to 3 to the converter channels.
// - Converter power-on turns port D pins 4 and 5 into low and high references.
// - Second-interrupt enable turns port D pin 6 into the second interrupt input.
// - Operating clock runs at half the oscillator rate.
// - Device drives its reset pin low throughout the power-on delay.
// - Reset pin pulled low from outside clears control state; port data and the power-on delay are not reset.
// - Port A pins also feed the keyboard interrupt sources.
// - Port B pins 5 to 7 offer a selectable reduced drive mode.
// - Second interrupt reacts to falling edges only, never to level.
// - Direction bits clear on reset; one means output, zero means input.
module mpfc_pin_ctrl
    import mpfc_pkg::*;
#(
    parameter int POR_OP_CYCLES = `MPFC_POR_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  portAIn,
    input  wire logic [7:0]  portBIn,
    input  wire logic [7:0]  portCIn,
    input  wire logic [7:0]  portDIn,
    output logic      [7:0]  portAOut,
    output logic      [7:0]  portBOut,
    output logic      [7:0]  portCOut,
    output logic      [7:0]  portDOut,
    output logic      [7:0]  portAOe,
    output logic      [7:0]  portBOe,
    output logic      [7:0]  portCOe,
    output logic      [7:0]  portDOe,
    output logic      [7:0]  portAPullUp,
    output logic      [7:0]  portBPullUp,
    output logic      [7:0]  portCPullUp,
    output logic      [7:0]  portDPullUp,
    output logic      [2:0]  portBLowDrive,
    output logic      [7:0]  kbdSrc,
    output logic      [3:0]  convChanEn,
    output logic      [1:0]  convRefEn,
    input  wire logic        extIntPin_n,
    output logic             extIntReq,
    output logic             secondIntReq,
    output logic             opClkEn,
    input  wire logic        rstPin_n,
    output logic             rstPinOut,
    output logic             rstPinOe
);

    if (POR_OP_CYCLES < 1 || POR_OP_CYCLES > 65535) begin : g_chk
        $error("POR_OP_CYCLES must lie in 1..65535.");
    end

    mpfc_ports_t pinIn;
    mpfc_ports_t data_ff, nxt_data, ddr_ff, nxt_ddr, pullSel;
    mpfc_ports_t pinOut_ff, pinOe_ff, pull_ff, nxt_out, nxt_oe, nxt_pull;
    mpfc_byte_t  opt_ff, nxt_opt, misc_ff, nxt_misc, conv_ff, nxt_conv, rdByte;
    mpfc_byte_t  altD;
    logic [31:0] datO_ff, nxt_datO;
    logic        ack_ff, nxt_ack, access, ctlRst;
    logic [3:0]  adrIdx;
    logic        opTick_ff, nxt_opTick;
    mpfc_rst_e   state_ff, nxt_state;
    logic [15:0] porCnt_ff, nxt_porCnt;
    logic        irqPrev_ff, nxt_irqPrev, int2Prev_ff, nxt_int2Prev;
    logic        extReq_ff, nxt_extReq, int2Req_ff, nxt_int2Req;
    logic [7:0]  kbd_ff;
    logic [2:0]  lowDrv_ff;
    logic [3:0]  chan_ff;
    logic [1:0]  ref_ff;

    assign pinIn  = {portDIn, portCIn, portBIn, portAIn};
    assign adrIdx = wb_adr_i[5:2];
    assign access = wb_cyc_i & wb_stb_i & ~ack_ff;
    // Power-on delay, the host reset and a low reset pin all clear control state.
    assign ctlRst = rst | ~rstPin_n | (state_ff == MPFC_POR);

    ////////////////////////////////////////////////////////////////////////////
    // Operating clock enable and power-on delay.
    always_comb begin
        nxt_opTick = ~opTick_ff;
        nxt_state  = state_ff;
        nxt_porCnt = porCnt_ff;
        if (state_ff == MPFC_POR && opTick_ff) begin
            if (porCnt_ff == 16'(POR_OP_CYCLES - 1)) begin
                nxt_state = MPFC_RUN;
            end else begin
                nxt_porCnt = porCnt_ff + 16'h0001;
            end
        end
    end

    // The reset pin is driven low while the power-on delay runs.
    always_ff @(posedge clk) begin
        if (rst) begin
            opTick_ff <= 1'b0;
            state_ff  <= MPFC_POR;
            porCnt_ff <= 16'h0000;
            rstPinOe  <= 1'b1;
            rstPinOut <= 1'b0;
        end else begin
            opTick_ff <= nxt_opTick;
            state_ff  <= nxt_state;
            porCnt_ff <= nxt_porCnt;
            rstPinOe  <= (nxt_state == MPFC_POR);
            rstPinOut <= 1'b0;
        end
    end
    assign opClkEn = opTick_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Register file on the bus; data sits in byte lane 0.
    always_comb begin
        nxt_data = data_ff;
        nxt_ddr  = ddr_ff;
        nxt_opt  = opt_ff;
        nxt_misc = misc_ff;
        nxt_conv = conv_ff;
        nxt_ack  = access;
        rdByte   = `MPFC_RST_BYTE;
        if (adrIdx < `MPFC_IDX_DDR) begin
            rdByte = (data_ff[adrIdx[1:0]] & ddr_ff[adrIdx[1:0]])
                   | (pinIn[adrIdx[1:0]] & ~ddr_ff[adrIdx[1:0]]);
            if (access && wb_we_i && wb_sel_i[0]) begin
                nxt_data[adrIdx[1:0]] = wb_dat_i[7:0];
            end
        end else if (adrIdx < `MPFC_IDX_DDR + 4'h4) begin
            rdByte = ddr_ff[adrIdx[1:0]];
            if (access && wb_we_i && wb_sel_i[0]) begin
                nxt_ddr[adrIdx[1:0]] = wb_dat_i[7:0];
            end
        end else if (adrIdx == `MPFC_IDX_OPT) begin
            rdByte = opt_ff;
            if (access && wb_we_i && wb_sel_i[0]) begin
                nxt_opt = {1'b0, wb_dat_i[6:0]};
            end
        end else if (adrIdx == `MPFC_IDX_MISC) begin
            rdByte = misc_ff;
            if (access && wb_we_i && wb_sel_i[0]) begin
                nxt_misc = {6'h00, wb_dat_i[1:0]};
            end
        end else if (adrIdx == `MPFC_IDX_CONV) begin
            rdByte = conv_ff;
            if (access && wb_we_i && wb_sel_i[0]) begin
                nxt_conv = {wb_dat_i[7], 7'h00};
            end
        end
        nxt_datO = access ? {24'h000000, rdByte} : 32'h00000000;
    end

    // Direction and options clear on any reset; port data only on the host one.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_ff <= {4{`MPFC_RST_BYTE}};
        end else begin
            data_ff <= nxt_data;
        end
        if (ctlRst) begin
            ddr_ff  <= {4{`MPFC_RST_BYTE}};
            opt_ff  <= `MPFC_RST_BYTE;
            misc_ff <= `MPFC_RST_BYTE;
            conv_ff <= `MPFC_RST_BYTE;
        end else begin
            ddr_ff  <= nxt_ddr;
            opt_ff  <= nxt_opt;
            misc_ff <= nxt_misc;
            conv_ff <= nxt_conv;
        end
        if (rst) begin
            ack_ff  <= 1'b0;
            datO_ff <= 32'h00000000;
        end else begin
            ack_ff  <= nxt_ack;
            datO_ff <= nxt_datO;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = datO_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, pull-ups and alternate functions per port.
    assign altD = ({8{conv_ff[`MPFC_CONV_ON]}} & `MPFC_PD_ALTMASK)
                | (8'(misc_ff[`MPFC_MISC_INT2]) << `MPFC_PD_INT2);
    assign pullSel[0] = {8{opt_ff[`MPFC_OPT_PAP]}};
    assign pullSel[1] = {{6{opt_ff[`MPFC_OPT_PBP]}}, opt_ff[`MPFC_OPT_PB1],
                         opt_ff[`MPFC_OPT_PB0]};
    assign pullSel[2] = {8{opt_ff[`MPFC_OPT_PCP]}};
    assign pullSel[3] = {8{opt_ff[`MPFC_OPT_PDP]}};

    for (genvar p = 0; p < 4; p++) begin : g_port
        // An alternate function on port D owns the pin and drops driver and pull-up.
        always_comb begin
            nxt_out[p]  = data_ff[p];
            nxt_oe[p]   = ddr_ff[p] & ~((p == 3) ? altD : 8'h00);
            nxt_pull[p] = pullSel[p] & ~ddr_ff[p] & ~((p == 3) ? altD : 8'h00);
        end
        always_ff @(posedge clk) begin
            if (rst) begin
                pinOut_ff[p] <= `MPFC_RST_BYTE;
                pinOe_ff[p]  <= `MPFC_RST_BYTE;
                pull_ff[p]   <= `MPFC_RST_BYTE;
            end else begin
                pinOut_ff[p] <= nxt_out[p];
                pinOe_ff[p]  <= nxt_oe[p];
                pull_ff[p]   <= nxt_pull[p];
            end
        end
    end
    assign {portDOut, portCOut, portBOut, portAOut}             = pinOut_ff;
    assign {portDOe, portCOe, portBOe, portAOe}                 = pinOe_ff;
    assign {portDPullUp, portCPullUp, portBPullUp, portAPullUp} = pull_ff;

    // Keyboard sources, reduced drive and converter routing.
    always_ff @(posedge clk) begin
        if (rst) begin
            kbd_ff    <= 8'hFF;
            lowDrv_ff <= 3'h0;
            chan_ff   <= 4'h0;
            ref_ff    <= 2'h0;
        end else begin
            kbd_ff    <= portAIn;
            lowDrv_ff <= {3{opt_ff[`MPFC_OPT_PIL]}};
            chan_ff   <= {4{conv_ff[`MPFC_CONV_ON]}};
            ref_ff    <= {2{conv_ff[`MPFC_CONV_ON]}};
        end
    end
    assign kbdSrc        = kbd_ff;
    assign portBLowDrive = lowDrv_ff;
    assign convChanEn    = chan_ff;
    assign convRefEn     = ref_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pins are sampled once per operating clock cycle.
    always_comb begin
        nxt_irqPrev  = opTick_ff ? extIntPin_n : irqPrev_ff;
        nxt_int2Prev = opTick_ff ? portDIn[`MPFC_PD_INT2] : int2Prev_ff;
        nxt_extReq   = opTick_ff & ~extIntPin_n
                     & (irqPrev_ff | misc_ff[`MPFC_MISC_LEVEL]);
        nxt_int2Req  = opTick_ff & misc_ff[`MPFC_MISC_INT2]
                     & int2Prev_ff & ~portDIn[`MPFC_PD_INT2];
    end

    // Requests are one-cycle pulses; none are raised while held in reset.
    always_ff @(posedge clk) begin
        if (ctlRst) begin
            irqPrev_ff  <= 1'b1;
            int2Prev_ff <= 1'b1;
            extReq_ff   <= 1'b0;
            int2Req_ff  <= 1'b0;
        end else begin
            irqPrev_ff  <= nxt_irqPrev;
            int2Prev_ff <= nxt_int2Prev;
            extReq_ff   <= nxt_extReq;
            int2Req_ff  <= nxt_int2Req;
        end
    end
    assign extIntReq    = extReq_ff;
    assign secondIntReq = int2Req_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    irq_level_a: assert property (opTick_ff && misc_ff[`MPFC_MISC_LEVEL] && !extIntPin_n
        && !ctlRst ##1 !ctlRst |-> extIntReq) else $error("Level request missed.");
    irq_edge_a: assert property (extIntReq && !$past(misc_ff[`MPFC_MISC_LEVEL])
        |-> $past(irqPrev_ff) && !$past(extIntPin_n)) else $error("Edge request without edge.");
    oe_reset_a: assert property (ctlRst ##1 1'b1 |=> pinOe_ff == 32'h00000000)
        else $error("Port not input after reset.");
    pull_input_a: assert property ((pull_ff & pinOe_ff) == 32'h00000000)
        else $error("Pull-up on output pin.");
    conv_route_a: assert property (conv_ff[`MPFC_CONV_ON] ##1 conv_ff[`MPFC_CONV_ON]
        |-> convChanEn == 4'hF && portDOe[3:0] == 4'h0) else $error("Channels not routed.");
    conv_ref_a: assert property (conv_ff[`MPFC_CONV_ON] ##1 conv_ff[`MPFC_CONV_ON]
        |-> convRefEn == 2'h3 && portDOe[5:4] == 2'h0) else $error("References not routed.");
    int2_edge_a: assert property (secondIntReq |-> $past(misc_ff[`MPFC_MISC_INT2])
        && $past(int2Prev_ff) && !$past(portDIn[`MPFC_PD_INT2])) else $error("Bad second request.");
    int2_nolvl_a: assert property (secondIntReq |=> !secondIntReq)
        else $error("Second interrupt acted on level.");
    op_half_a: assert property (!$past(rst) |-> opClkEn != $past(opClkEn))
        else $error("Operating clock not half rate.");
    por_hold_a: assert property ($fell(rstPinOe) |-> $past(porCnt_ff)
        == 16'(POR_OP_CYCLES - 1) && !rstPinOut) else $error("Reset pin released early.");
    ext_reset_a: assert property (!rstPin_n |=> ddr_ff == 32'h00000000 && conv_ff == 8'h00)
        else $error("Pin reset ignored.");
    kbd_src_a: assert property (!$past(rst) |-> kbdSrc == $past(portAIn))
        else $error("Keyboard source stale.");
    low_drive_a: assert property (opt_ff[`MPFC_OPT_PIL] |=> portBLowDrive == 3'h7)
        else $error("Reduced drive not applied.");
    int2_oe_a: assert property (misc_ff[`MPFC_MISC_INT2] ##1 misc_ff[`MPFC_MISC_INT2]
        |-> !portDOe[`MPFC_PD_INT2]) else $error("Driver on second interrupt pin.");

    cv_por_done: cover property ($fell(rstPinOe));
    cv_edge_irq: cover property (extIntReq && !misc_ff[`MPFC_MISC_LEVEL]);
    cv_second: cover property (secondIntReq);
    cv_conv_on: cover property (convChanEn == 4'hF);

endmodule : mpfc_pin_ctrl

/* File: pkg/mpfc_map.svh */
`ifndef MPFC_MAP_SVH
`define MPFC_MAP_SVH
// Register indices; the byte address on the bus is four times the index.
`define MPFC_IDX_DATA    4'h0
`define MPFC_IDX_DDR     4'h4
`define MPFC_IDX_OPT     4'hA
`define MPFC_IDX_MISC    4'hC
`define MPFC_IDX_CONV    4'hE
// Option register fields.
`define MPFC_OPT_PB0     0
`define MPFC_OPT_PB1     1
`define MPFC_OPT_PBP     2
`define MPFC_OPT_PCP     3
`define MPFC_OPT_PDP     4
`define MPFC_OPT_PIL     5
`define MPFC_OPT_PAP     6
// Miscellaneous control fields.
`define MPFC_MISC_LEVEL  0
`define MPFC_MISC_INT2   1
// Converter control field.
`define MPFC_CONV_ON     7
// Port D pin roles.
`define MPFC_PD_INT2     6
`define MPFC_PD_ALTMASK  8'h3F
// Reset values and power-on delay in operating clock cycles.
`define MPFC_RST_BYTE    8'h00
`define MPFC_POR_CYCLES  4096
`endif

/* File: pkg/mpfc_pkg.sv */
package mpfc_pkg;
    typedef logic [7:0] mpfc_byte_t;
    typedef logic [3:0][7:0] mpfc_ports_t;
    typedef enum logic [0:0] {
        MPFC_POR = 1'b0,
        MPFC_RUN = 1'b1
    } mpfc_rst_e;
endpackage : mpfc_pkg

/* File: testbench/mpfc_board_model.sv */
`timescale 1ns/100ps
// Board side of the pins: resolves each pin level from the device drive and board sources.
module mpfc_board_model
    import mpfc_pkg::*;
(
    input  wire mpfc_ports_t outs,
    input  wire mpfc_ports_t oes,
    input  wire mpfc_ports_t ext,
    output mpfc_ports_t      pins,
    input  wire logic        rstOut,
    input  wire logic        rstOe,
    input  wire logic        rstDrvN,
    output logic             rstPinN
);
    // A driving device wins; otherwise the board source sets the level.
    assign pins = (oes & outs) | (~oes & ext);
    // The pull-up holds the line high unless the device or the board pulls it low.
    assign rstPinN = rstDrvN & ~(rstOe & ~rstOut);
endmodule : mpfc_board_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "mpfc_map.svh"
module tb_top
    import mpfc_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        intN = 1'b1, rstDrvN = 1'b1, ack, req1, req2, opEn, rstOut, rstOe, rstPinN, p;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0, chan;
    logic [31:0] datI = 32'h00000000, datO;
    logic [7:0]  q, opt, kbd, ddr [4], dat [4];
    logic [2:0]  lowDrv;
    logic [1:0]  refEn;
    mpfc_ports_t outs, oes, pulls, pins, ext = '0;
    int          error_cnt = 0, check_count = 0, c1, c2, n;
    // Short power-on delay so the run stays brief.
    localparam int POR_CYC = 4;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock, design and board.
    always #2.5 clk = ~clk;
    mpfc_pin_ctrl #(.POR_OP_CYCLES(POR_CYC)) i_mpfc_pin_ctrl (.clk(clk), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .portAIn(pins[0]), .portBIn(pins[1]), .portCIn(pins[2]), .portDIn(pins[3]),
        .portAOut(outs[0]), .portBOut(outs[1]), .portCOut(outs[2]), .portDOut(outs[3]),
        .portAOe(oes[0]), .portBOe(oes[1]), .portCOe(oes[2]), .portDOe(oes[3]),
        .portAPullUp(pulls[0]), .portBPullUp(pulls[1]), .portCPullUp(pulls[2]),
        .portDPullUp(pulls[3]), .portBLowDrive(lowDrv), .kbdSrc(kbd), .convChanEn(chan),
        .convRefEn(refEn), .extIntPin_n(intN), .extIntReq(req1), .secondIntReq(req2),
        .opClkEn(opEn), .rstPin_n(rstPinN), .rstPinOut(rstOut), .rstPinOe(rstOe));
    mpfc_board_model i_mpfc_board_model (.outs(outs), .oes(oes), .ext(ext), .pins(pins),
        .rstOut(rstOut), .rstOe(rstOe), .rstDrvN(rstDrvN), .rstPinN(rstPinN));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask : chk

    // One classic bus cycle, held until ack is sampled, then one idle cycle.
    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hF;
        datI <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (n >= 64) begin
            error_cnt++;
            conclude();
        end
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // Counts request pulses on both interrupt outputs over a number of cycles.
    task automatic count(input int k);
        c1 = 0;
        c2 = 0;
        repeat (k) begin
            @(posedge clk);
            if (req1 === 1'b1)
                c1++;
            if (req2 === 1'b1)
                c2++;
        end
    endtask : count

    function automatic logic [7:0] pullB(input logic [7:0] o, input logic [7:0] d);
        return {{6{o[2]}}, o[1], o[0]} & ~d;
    endfunction : pullB

    function automatic logic [7:0] rdExp(input logic [7:0] l, input logic [7:0] pn,
                                         input logic [7:0] d);
        return (l & d) | (pn & ~d);
    endfunction : rdExp

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h6123EF78));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(rstOe, 1'b1);
        chk(oes, 32'h00000000);
        n = 0;
        while (rstOe !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(n, 2 * POR_CYC);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, `MPFC_IDX_DDR + 4'(i), 8'h00);
            chk(q, 8'h00);
        end
        repeat (4) begin
            for (int i = 0; i < 4; i++) begin
                ddr[i] = 8'($urandom);
                dat[i] = 8'($urandom);
                ext[i] <= 8'($urandom);
                wb(1'b1, 4'(i), dat[i]);
                wb(1'b1, `MPFC_IDX_DDR + 4'(i), ddr[i]);
            end
            opt = 8'($urandom) & 8'h7F;
            wb(1'b1, `MPFC_IDX_OPT, opt);
            for (int i = 0; i < 4; i++) begin
                chk(oes[i], ddr[i]);
                chk(outs[i], dat[i]);
                wb(1'b0, 4'(i), 8'h00);
                chk(q, rdExp(dat[i], ext[i], ddr[i]));
            end
            chk(pulls[0], opt[6] ? 8'(~ddr[0]) : 8'h00);
            chk(pulls[1], pullB(opt, ddr[1]));
            chk(pulls[2], opt[3] ? 8'(~ddr[2]) : 8'h00);
            chk(pulls[3], opt[4] ? 8'(~ddr[3]) : 8'h00);
            chk(lowDrv, {3{opt[5]}});
            chk(kbd, pins[0]);
        end
        // Operating clock enable alternates on every oscillator cycle.
        p = opEn;
        repeat (6) begin
            @(posedge clk);
            chk(opEn, !p);
            p = opEn;
        end
        // Edge-only, then edge plus level sensitivity on the interrupt pin.
        wb(1'b1, `MPFC_IDX_MISC, 8'h00);
        intN <= 1'b0;
        count(20);
        chk(c1, 1);
        intN <= 1'b1;
        wb(1'b1, `MPFC_IDX_MISC, 8'h01);
        intN <= 1'b0;
        count(20);
        chk(c1 >= 9 && c1 <= 11, 1'b1);
        intN <= 1'b1;
        // Alternate functions on port D, second interrupt held low in level mode.
        ext[3][6] <= 1'b1;
        wb(1'b1, `MPFC_IDX_DDR + 4'h3, 8'hFF);
        wb(1'b1, `MPFC_IDX_CONV, 8'h80);
        wb(1'b1, `MPFC_IDX_MISC, 8'h03);
        chk(chan, 4'hF);
        chk(refEn, 2'h3);
        chk(oes[3], 8'h80);
        // Let the second interrupt input sample the released high level first.
        repeat (2) @(posedge clk);
        ext[3][6] <= 1'b0;
        count(20);
        chk(c2, 1);
        // Board pulls the reset pin low.
        rstDrvN <= 1'b0;
        repeat (3) @(posedge clk);
        rstDrvN <= 1'b1;
        repeat (4) @(posedge clk);
        chk(oes, 32'h00000000);
        chk(chan, 4'h0);
        chk(refEn, 2'h0);
        chk(outs[0], dat[0]);
        wb(1'b0, `MPFC_IDX_DDR, 8'h00);
        chk(q, 8'h00);
        conclude();
    end
endmodule : tb_top
